/* File: rtl/dct_pkg.sv */
package dct_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   // Printed offsets are halfword aligned, so each is kept as printed
   // and the slave decodes four times its distance from the base.
   localparam int          DCT_AW          = 6;
   localparam logic [31:0] DCT_BASE        = 32'h5000352E;
   localparam logic [31:0] DCT_IDX_OFS     = 32'h5000352E;
   localparam logic [31:0] DCT_SRC_LO_OFS  = 32'h50003530;
   localparam logic [31:0] DCT_SRC_HI_OFS  = 32'h50003532;
   localparam logic [31:0] DCT_DST_LO_OFS  = 32'h50003534;
   localparam logic [31:0] DCT_DST_HI_OFS  = 32'h50003536;
   localparam logic [31:0] DCT_THRESH_OFS  = 32'h50003538;
   localparam logic [31:0] DCT_LEN_OFS     = 32'h5000353A;
   localparam logic [31:0] DCT_CTRL_OFS    = 32'h5000353C;

   localparam logic [DCT_AW-1:0] DCT_A_IDX    = DCT_AW'((DCT_IDX_OFS - DCT_BASE) << 2);
   localparam logic [DCT_AW-1:0] DCT_A_SRC_LO = DCT_AW'((DCT_SRC_LO_OFS - DCT_BASE) << 2);
   localparam logic [DCT_AW-1:0] DCT_A_SRC_HI = DCT_AW'((DCT_SRC_HI_OFS - DCT_BASE) << 2);
   localparam logic [DCT_AW-1:0] DCT_A_DST_LO = DCT_AW'((DCT_DST_LO_OFS - DCT_BASE) << 2);
   localparam logic [DCT_AW-1:0] DCT_A_DST_HI = DCT_AW'((DCT_DST_HI_OFS - DCT_BASE) << 2);
   localparam logic [DCT_AW-1:0] DCT_A_THRESH = DCT_AW'((DCT_THRESH_OFS - DCT_BASE) << 2);
   localparam logic [DCT_AW-1:0] DCT_A_LEN    = DCT_AW'((DCT_LEN_OFS - DCT_BASE) << 2);
   localparam logic [DCT_AW-1:0] DCT_A_CTRL   = DCT_AW'((DCT_CTRL_OFS - DCT_BASE) << 2);

   localparam logic [15:0] DCT_RST  = 16'h0000;
   localparam logic [15:0] DCT_ONE  = 16'h0001;
   localparam int          DCT_HT_BUSY = 1;

   // ---------------------------------------------------------------
   // Item width codes
   // ---------------------------------------------------------------
   localparam logic [1:0] DCT_W1 = 2'h0;
   localparam logic [1:0] DCT_W2 = 2'h1;
   localparam logic [1:0] DCT_W4 = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] rsvd;
      logic       fill;
      logic       yield;
      logic [2:0] channel_priority;
      logic       circular;
      logic       src_increment_en;
      logic       dst_increment_en;
      logic       request_triggered;
      logic       irq_en;
      logic [1:0] item_width;
      logic       active;
   } dct_ctrl_t;

   typedef struct packed {
      logic        req;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } dct_mem_t;

   typedef enum logic [2:0] {
      DCT_IDLE  = 3'h0,
      DCT_ARB   = 3'h1,
      DCT_READ  = 3'h3,
      DCT_WRITE = 3'h2,
      DCT_YIELD = 3'h6
   } dct_fsm_t;

   typedef struct packed {
      dct_fsm_t          fsm;
      logic [15:0]       src_lo;
      logic [15:0]       src_hi;
      logic [15:0]       dst_lo;
      logic [15:0]       dst_hi;
      logic [15:0]       thresh;
      logic [15:0]       len;
      logic [15:0]       idx;
      dct_ctrl_t         ctrl;
      logic [31:0]       data;
      dct_mem_t          mem;
      logic              bus_req;
      logic              hold_bus;
      logic              lock;
      logic              irq;
      logic              dreq_ack;
      logic              ph_valid;
      logic              ph_write;
      logic [DCT_AW-1:0] ph_addr;
      logic [31:0]       hrdata;
      logic              rdy;
      logic              resp;
   } dct_state_t;

endpackage

/* File: rtl/dct_channel.sv */
`timescale 1ns/1ns
// Operation
// R1: Read-only 16-bit item index counts items fetched in the running transfer.
// R2: Item index returns to zero when a transfer completes.
// R3: Next addresses come from index, both increment enables and item width.
// R4: Source start address is two writable 16-bit halves, reset zero.
// R5: Destination start address is two writable 16-bit halves, reset zero.
// R6: After each item, before index increments, interrupt when threshold equals index.
// R7: Threshold interrupt only while the interrupt gate bit is one.
// R8: Length value N moves N plus one items.
// R9: Fill mode fetches source once and writes it to every destination.
// R10: Software sets destination increment in fill mode; source increment ignored.
// R11: A fill transfer is never preempted by another channel.
// R12: Software should not combine fill mode with request triggering.
// R13: Yield clear: back-to-back copy, lower-priority masters kept off the bus.
// R14: Yield set: one idle cycle after each store frees the bus.
// R15: Yield is ignored under request triggering.
// R16: 3-bit priority decides grants; larger value wins.
// R17: Equal priority: lower channel number wins.
// R18: Circular clear: stop after length and clear active bit.
// R19: Circular under request triggering: stay active, reset index, restart.
// R20: Source increment set: advance 1, 2 or 4 bytes per width code.
// R21: Source increment clear: same source address for every item.
// R22: Destination increment: fixed when clear, advance by item width when set.
// R23: Request trigger clear starts at once; set waits for peripheral request.
// R24: Width codes 00, 01, 10 give 1, 2, 4 bytes; 11 reserved.
// R25: Active bit enables channel; cleared on completion unless circular; the code keeps it set only when circular and request triggering are both set.
// R26: Each item is a bus read from source then a bus write to destination.
module dct_channel
   import dct_pkg::*;
#(
   parameter int NUM_CH = 8,
   parameter int CH_ID  = 3
)
(
   // Clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // AHB-Lite register slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // Item mover
   output dct_mem_t                    mem_o,
   input  wire logic                   mem_ack,
   input  wire logic [31:0]            mem_rdata,
   // Arbitration among channels
   input  wire logic [NUM_CH-1:0]      rival_req,
   input  wire logic [NUM_CH-1:0][2:0] rival_prio,
   input  wire logic                   rival_lock,
   output logic                        bus_req,
   output logic                        hold_bus,
   output logic                        bus_lock,
   output logic [2:0]                  channel_priority,
   // Peripheral request
   input  wire logic                   dreq,
   output logic                        dreq_ack,
   // Threshold event
   output logic                        irq
);

   // ---------------------------------------------------------------
   // Address step
   // ---------------------------------------------------------------
   function automatic logic [31:0] dct_step
   (
      input logic        en,
      input logic [1:0]  w,
      input logic [15:0] i
   );
      logic [31:0] v;
      v = 32'(i);
      if (!en)
      begin
         return '0;
      end
      // Reserved code 11 steps like a byte
      case (w)
         DCT_W2:  return v << 1;
         DCT_W4:  return v << 2;
         default: return v;
      endcase
   endfunction

   dct_state_t  s_q;
   dct_state_t  s_d;
   dct_ctrl_t   c;
   logic        yield_eff;
   logic        win;
   logic        acc;
   logic        last;
   logic [31:0] src_addr;
   logic [31:0] dst_addr;
   logic [NUM_CH-1:0] beaten;

   assign c = s_q.ctrl;

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   for (genvar j = 0; j < NUM_CH; j++)
   begin : g_arb
      assign beaten[j] = (j != CH_ID) && rival_req[j]
                         && ((rival_prio[j] > c.channel_priority)    // R16
                         || (rival_prio[j] == c.channel_priority
                         && j < CH_ID));                             // R17
   end

   // A fill in another channel holds the bus to its end
   assign win = !(|beaten) && !rival_lock;

   // Request-triggered peripherals pace the transfer themselves
   assign yield_eff = c.yield && !c.request_triggered;               // R15

   assign src_addr = {s_q.src_hi, s_q.src_lo}
                     + dct_step(c.src_increment_en, c.item_width, s_q.idx); // R3 R20 R21
   assign dst_addr = {s_q.dst_hi, s_q.dst_lo}
                     + dct_step(c.dst_increment_en, c.item_width, s_q.idx); // R3 R22

   assign last = (s_q.idx == s_q.len);                               // R8
   assign acc  = hsel && htrans[DCT_HT_BUSY] && hready;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.irq = 1'b0;
      s_d.dreq_ack = 1'b0;
      s_d.rdy = 1'b1;
      s_d.resp = 1'b0;

      case (s_q.fsm)
         DCT_IDLE:
         begin
            if (c.active && (!c.request_triggered || dreq))          // R23 R25
            begin
               s_d.fsm = DCT_ARB;
               s_d.bus_req = 1'b1;
            end
         end

         DCT_ARB:
         begin
            if (!c.active)
            begin
               s_d.fsm = DCT_IDLE;
               s_d.bus_req = 1'b0;
               s_d.hold_bus = 1'b0;
               s_d.lock = 1'b0;
            end
            else if (win || s_q.lock)
            begin
               s_d.hold_bus = !yield_eff;                            // R13
               s_d.lock = c.fill;                                    // R11
               s_d.mem.req = 1'b1;
               // R24
               s_d.mem.size = (c.item_width == DCT_W4) ? DCT_W4 :
                              (c.item_width == DCT_W2) ? DCT_W2 : DCT_W1;
               if (c.fill && s_q.idx != DCT_RST)
               begin
                  // Later fill items reuse the single fetched value
                  s_d.mem.write = 1'b1;                              // R9
                  s_d.mem.addr = dst_addr;
                  s_d.mem.wdata = s_q.data;
                  s_d.fsm = DCT_WRITE;
               end
               else
               begin
                  s_d.mem.write = 1'b0;                              // R26
                  s_d.mem.addr = src_addr;
                  s_d.fsm = DCT_READ;
               end
            end
         end

         DCT_READ:
         begin
            if (mem_ack)
            begin
               s_d.data = mem_rdata;
               s_d.mem.write = 1'b1;                                 // R26
               s_d.mem.addr = dst_addr;
               s_d.mem.wdata = mem_rdata;
               s_d.fsm = DCT_WRITE;
            end
         end

         DCT_WRITE:
         begin
            if (mem_ack)
            begin
               s_d.mem.req = 1'b0;
               s_d.mem.write = 1'b0;
               s_d.irq = c.irq_en && (s_q.thresh == s_q.idx);        // R6 R7
               s_d.dreq_ack = c.request_triggered;
               if (last)
               begin
                  s_d.idx = DCT_RST;                                 // R2 R19
                  s_d.fsm = DCT_IDLE;
                  s_d.bus_req = 1'b0;
                  s_d.hold_bus = 1'b0;
                  s_d.lock = 1'b0;
                  if (!(c.circular && c.request_triggered))
                  begin
                     s_d.ctrl.active = 1'b0;                         // R18 R25
                  end
               end
               else
               begin
                  s_d.idx = s_q.idx + DCT_ONE;                       // R1
                  if (c.request_triggered)
                  begin
                     // Each further item waits for a fresh request
                     s_d.fsm = DCT_IDLE;
                     s_d.bus_req = 1'b0;
                     s_d.hold_bus = 1'b0;
                  end
                  else if (yield_eff)
                  begin
                     s_d.fsm = DCT_YIELD;                            // R14
                     s_d.bus_req = 1'b0;
                     s_d.hold_bus = 1'b0;
                  end
                  else
                  begin
                     s_d.fsm = DCT_ARB;                              // R13
                  end
               end
            end
         end

         DCT_YIELD:
         begin
            s_d.fsm = DCT_ARB;
            s_d.bus_req = 1'b1;
         end

         default:
         begin
            s_d.fsm = DCT_IDLE;
         end
      endcase

      // -------------------------------------------------------------
      // Register writes, data phase
      // -------------------------------------------------------------
      // Applied after the sequencer so a software write to the
      // control word wins over the automatic clear of the active bit.
      if (s_q.ph_valid && s_q.ph_write)
      begin
         case (s_q.ph_addr)
            DCT_A_SRC_LO: s_d.src_lo = hwdata[15:0];                 // R4
            DCT_A_SRC_HI: s_d.src_hi = hwdata[15:0];                 // R4
            DCT_A_DST_LO: s_d.dst_lo = hwdata[15:0];                 // R5
            DCT_A_DST_HI: s_d.dst_hi = hwdata[15:0];                 // R5
            DCT_A_THRESH: s_d.thresh = hwdata[15:0];
            DCT_A_LEN:    s_d.len = hwdata[15:0];
            DCT_A_CTRL:
            begin
               s_d.ctrl = dct_ctrl_t'(hwdata[15:0]);
               s_d.ctrl.rsvd = '0;
               // Switching off abandons the transfer; restart from item zero
               if (!s_d.ctrl.active)
               begin
                  s_d.idx = DCT_RST;
               end
            end
            default:
            begin
            end
         endcase
      end

      // -------------------------------------------------------------
      // Address phase capture and read data
      // -------------------------------------------------------------
      s_d.ph_valid = acc;
      s_d.ph_write = acc && hwrite;
      s_d.ph_addr = haddr[DCT_AW-1:0];
      if (acc && !hwrite)
      begin
         // Read mux looks at the next state, so a read right after a
         // write returns the freshly written value.
         case (haddr[DCT_AW-1:0])
            DCT_A_IDX:    s_d.hrdata = 32'(s_d.idx);                 // R1
            DCT_A_SRC_LO: s_d.hrdata = 32'(s_d.src_lo);
            DCT_A_SRC_HI: s_d.hrdata = 32'(s_d.src_hi);
            DCT_A_DST_LO: s_d.hrdata = 32'(s_d.dst_lo);
            DCT_A_DST_HI: s_d.hrdata = 32'(s_d.dst_hi);
            DCT_A_THRESH: s_d.hrdata = 32'(s_d.thresh);
            DCT_A_LEN:    s_d.hrdata = 32'(s_d.len);
            DCT_A_CTRL:   s_d.hrdata = 32'(s_d.ctrl);
            default:      s_d.hrdata = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q <= '0;
         s_q.fsm <= DCT_IDLE;
         s_q.src_lo <= DCT_RST;
         s_q.src_hi <= DCT_RST;
         s_q.dst_lo <= DCT_RST;
         s_q.dst_hi <= DCT_RST;
         s_q.thresh <= DCT_RST;
         s_q.len <= DCT_RST;
         s_q.idx <= DCT_RST;
         s_q.ctrl <= dct_ctrl_t'(DCT_RST);
         s_q.rdy <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hreadyout        = s_q.rdy;
   assign hresp            = s_q.resp;
   assign hrdata           = s_q.hrdata;
   assign mem_o            = s_q.mem;
   assign bus_req          = s_q.bus_req;
   assign hold_bus         = s_q.hold_bus;
   assign bus_lock         = s_q.lock;
   assign channel_priority = s_q.ctrl.channel_priority;
   assign dreq_ack         = s_q.dreq_ack;
   assign irq              = s_q.irq;

endmodule

/* File: verification/dct_channel_properties.sv */
`timescale 1ns/1ns
module dct_channel_properties
   import dct_pkg::*;
#(
   parameter int NUM_CH = 8,
   parameter int CH_ID  = 3
)
(
   // Clock, reset and register bus
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire logic [31:0]            haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic [31:0]            hwdata,
   input wire logic                   hready,
   // Item mover, arbitration and events
   input wire dct_mem_t               mem_o,
   input wire logic                   mem_ack,
   input wire logic [NUM_CH-1:0]      rival_req,
   input wire logic [NUM_CH-1:0][2:0] rival_prio,
   input wire logic                   rival_lock,
   input wire logic                   bus_req,
   input wire logic                   hold_bus,
   input wire logic                   bus_lock,
   input wire logic [2:0]             channel_priority,
   input wire logic                   dreq_ack,
   input wire logic                   irq
);
   // ---------------------------------------------------------------
   // Control mirror
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic        wp_q;
   logic [15:0] ctl_q;
   dct_ctrl_t   c;
   logic        beaten;
   logic [1:0]  sz_e;

   assign c = dct_ctrl_t'(ctl_q);

   // Mode bits are taken from the bus, not the design, so a lost write shows up
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wp_q  <= 1'b0;
         ctl_q <= 16'h0000;
      end
      else if (hready)
      begin
         wp_q <= hsel && htrans[1] && hwrite && haddr[5:0] == DCT_A_CTRL;
         if (wp_q)
            ctl_q <= hwdata[15:0];
      end
   end

   always_comb
   begin
      beaten = 1'b0;
      sz_e = (c.item_width == DCT_W4) ? 2'h2 : (c.item_width == DCT_W2) ? 2'h1 : 2'h0;
      for (int i = 0; i < NUM_CH; i++)
         if (i != CH_ID && rival_req[i] && (rival_prio[i] > channel_priority ||
             (rival_prio[i] == channel_priority && i < CH_ID)))
            beaten = 1'b1;
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_req_hold: assert property (mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o))
      else $error("item request changed before its ack");
   a_read_then_write: assert property (mem_o.req && mem_ack && !mem_o.write |=> mem_o.req && mem_o.write)
      else $error("read ack not followed by a store");
   a_size_code: assert property (mem_o.req |-> mem_o.size == sz_e)
      else $error("item size does not match width code");
   a_irq_source: assert property (irq |-> $past(mem_ack && mem_o.req && mem_o.write))
      else $error("threshold event without a store ack");
   a_irq_gate: assert property (irq |-> c.irq_en)
      else $error("threshold event while gate is off");
   a_yield_gap: assert property (mem_ack && mem_o.write && c.yield && !c.request_triggered |=> !bus_req)
      else $error("no free cycle after store in yield mode");
   a_hold_bus: assert property (mem_o.req && !c.yield && !c.request_triggered |-> hold_bus)
      else $error("blocking transfer without bus hold");
   a_fill_lock: assert property (mem_o.req && mem_o.write && c.fill |-> bus_lock)
      else $error("fill store without lock");
   a_arb_loss: assert property ($rose(mem_o.req) && !bus_lock |-> !$past(beaten || rival_lock))
      else $error("request started while a rival should win");
   a_dreq_ack: assert property (dreq_ack |-> $past(mem_ack && mem_o.write))
      else $error("request ack without a store");

   c_irq: cover property (irq);
   c_fill: cover property (bus_lock && mem_o.req);
   c_dreq: cover property (dreq_ack);
endmodule

/* File: verification/dct_mem_model.sv */
`timescale 1ns/1ns
module dct_mem_model
   import dct_pkg::*;
(
   // Clock and reset
   input  wire logic     hclk,
   input  wire logic     hresetn,
   // Item mover side
   input  wire dct_mem_t mem_i,
   input  wire logic     slow,
   output logic          mem_ack,
   output logic [31:0]   mem_rdata
);
   logic [1:0] wait_q;

   // Read data is only valid with the ack; otherwise it toggles every cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wait_q    <= 2'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h00000000;
      end
      else
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_i.req && !mem_ack)
         begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == (slow ? 2'h3 : 2'h0))
            begin
               wait_q  <= 2'h0;
               mem_ack <= 1'b1;
               if (!mem_i.write)
                  mem_rdata <= {mem_i.addr[15:0], ~mem_i.addr[15:0]};
            end
         end
      end
   end
endmodule

/* File: verification/dct_channel_tb.sv */
`timescale 1ns/1ns
module dct_channel_tb
   import dct_pkg::*;
;
   localparam logic [31:0] SA = 32'h00011000;
   localparam logic [31:0] DA = 32'h00022000;

   logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic             dreq = 1'b0, rival_lock = 1'b0, slow = 1'b0;
   logic             mem_ack, hreadyout, hresp, bus_req, hold_bus, bus_lock, dreq_ack, irq;
   logic [1:0]       htrans = 2'h0;
   logic [2:0]       hsize = 3'h0, chp;
   logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, mem_rdata, msk;
   logic [7:0]       rival_req = 8'h00;
   logic [7:0][2:0]  rival_prio = '0;
   dct_mem_t         mem_o;
   int               errors = 0, checks = 0, nirq = 0, cyc = 0;
   logic [64:0]      lg[$];

   always #4 hclk = ~hclk;

   dct_channel #(.NUM_CH(8), .CH_ID(3)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_o, .mem_ack, .mem_rdata, .rival_req,
      .rival_prio, .rival_lock, .bus_req, .hold_bus, .bus_lock, .channel_priority(chp), .dreq, .dreq_ack, .irq);
   dct_mem_model mem_u (.hclk, .hresetn, .mem_i(mem_o), .slow, .mem_ack, .mem_rdata);

   // ---------------------------------------------------------------
   // Monitor, timeout and helpers
   // ---------------------------------------------------------------
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         close_out();
      end
      if (irq === 1'b1)
         nirq++;
      if (mem_o.req === 1'b1 && mem_ack === 1'b1)
         lg.push_back({mem_o.write, mem_o.addr, mem_o.write ? mem_o.wdata : mem_rdata});
   end

   function automatic logic [31:0] ed(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction

   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask

   task chk_op(input logic w, input logic [31:0] a, input logic [31:0] d);
      logic [64:0] g;
      g = 'X;
      if (lg.size() > 0)
         g = lg.pop_front();
      checks++;
      if ({g[64:32], g[31:0] & msk} !== {w, a, d & msk})
      begin
         errors++;
         $display("mismatch %0t item %h exp %h %h", $time, g, a, d);
      end
   endtask

   task aph(input logic [5:0] a, input logic w);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {26'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
   endtask

   task wr(input logic [5:0] a, input logic [15:0] d);
      aph(a, 1'b1);
      hwdata <= {16'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task rd(input logic [5:0] a);
      aph(a, 1'b0);
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task rc(input logic [5:0] a, input logic [31:0] e);
      rd(a);
      chk(hrdata, e);
      chk(32'(hresp), 32'h00000000);
   endtask

   // Polls the active bit without counting; bounded so a stuck channel still ends the scenario
   task wd();
      for (int i = 0; i < 100; i++)
      begin
         rd(DCT_A_CTRL);
         if (hrdata[0] !== 1'b1)
            break;
      end
   endtask

   // One-cycle request: a level still high when the ack shows would start another item
   task dp();
      @(posedge hclk);
      dreq <= 1'b1;
      @(posedge hclk);
      dreq <= 1'b0;
      do @(posedge hclk); while (dreq_ack !== 1'b1);
      repeat (4) @(posedge hclk);
   endtask

   task close_out();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      msk = 32'hFFFFFFFF;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a < 64; a += 8)
         rc(6'(a), 32'h0);
      wr(DCT_A_SRC_LO, SA[15:0]);
      wr(DCT_A_SRC_HI, SA[31:16]);
      wr(DCT_A_DST_LO, DA[15:0]);
      wr(DCT_A_DST_HI, DA[31:16]);
      rc(DCT_A_SRC_LO, 32'h00001000);
      rc(DCT_A_SRC_HI, 32'h00000001);
      rc(DCT_A_DST_LO, 32'h00002000);
      rc(DCT_A_DST_HI, 32'h00000002);
      wr(6'h04, 16'hBEEF);
      rc(6'h04, 32'h0);
      wr(DCT_A_CTRL, 16'hFFFE);
      rc(DCT_A_CTRL, 32'h00001FFE);
      chk(32'(chp), 32'h00000007);
      // Copy of three half-words, held off first by an equal rival of lower number
      wr(DCT_A_LEN, 16'h0002);
      wr(DCT_A_THRESH, 16'h0001);
      rival_req <= 8'h01;
      wr(DCT_A_CTRL, 16'h006B);
      repeat (20) @(posedge hclk);
      chk(lg.size(), 32'h0);
      rival_req <= 8'h10;
      wd();
      chk(hrdata, 32'h0000006A);
      rc(DCT_A_IDX, 32'h0);
      msk = 32'h0000FFFF;
      for (int i = 0; i < 3; i++)
      begin
         chk_op(1'b0, SA + 2 * i, ed(SA + 2 * i));
         chk_op(1'b1, DA + 2 * i, ed(SA + 2 * i));
      end
      chk(nirq, 32'h1);
      // Fill of four words from one fetch, gate off
      msk = 32'hFFFFFFFF;
      wr(DCT_A_LEN, 16'h0003);
      wr(DCT_A_THRESH, 16'h0000);
      wr(DCT_A_CTRL, 16'h1065);
      wd();
      chk_op(1'b0, SA, ed(SA));
      for (int i = 0; i < 4; i++)
         chk_op(1'b1, DA + 4 * i, ed(SA));
      chk(nirq, 32'h1);
      // Fixed addresses, byte items, yielding, slow memory
      slow <= 1'b1;
      msk = 32'h000000FF;
      wr(DCT_A_LEN, 16'h0001);
      wr(DCT_A_THRESH, 16'h0001);
      wr(DCT_A_CTRL, 16'h0809);
      wd();
      for (int i = 0; i < 2; i++)
      begin
         chk_op(1'b0, SA, ed(SA));
         chk_op(1'b1, DA, ed(SA));
      end
      chk(nirq, 32'h2);
      // Request-triggered circular run: the third item restarts at the start
      slow <= 1'b0;
      msk = 32'hFFFFFFFF;
      wr(DCT_A_CTRL, 16'h08B5);
      for (int k = 0; k < 3; k++)
      begin
         dp();
         chk_op(1'b0, SA, ed(SA));
         chk_op(1'b1, DA + 4 * (k % 2), ed(SA));
         rc(DCT_A_IDX, 32'((k + 1) % 2));
      end
      rc(DCT_A_CTRL, 32'h000008B5);
      wr(DCT_A_CTRL, 16'h0000);
      chk(lg.size(), 32'h0);
      close_out();
   end
endmodule

bind dct_channel dct_channel_properties #(.NUM_CH(NUM_CH), .CH_ID(CH_ID)) chk_u (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .mem_o, .mem_ack, .rival_req, .rival_prio, .rival_lock,
   .bus_req, .hold_bus, .bus_lock, .channel_priority, .dreq_ack, .irq);
